// >>> logic/mcu_exec_core.sv
// Instruction execution core of an 8-bit microcontroller
// Notes on behaviour
// - Most instructions take one cycle; jump, call, table read take two.
// - One instruction cycle is four system clock periods.
// - Writing the pc low byte jumps there and adds one cycle.
// - A skip test costs one cycle, plus one when it skips.
// - Transfers: memory to accumulator, accumulator to memory, constant in.
// - Add reports carry above 255; subtract reports borrow below zero.
// - Increment and decrement change the operand by exactly one.
// - Logical operations set zero flag when the result is zero.
// - Rotates move one bit; carry variants put the lost bit in carry.
// - Call saves next address; return resumes at that address.
// - Jump loads the target without saving a return address.
// - Conditional branch tests a byte or bit, then continues or skips.
// - Bit set and clear change only the chosen bit of the byte.
// - Table read fetches program memory data into data memory.
// - An instruction enters power down; others control the watchdog.
// - Moves between memory locations route through the accumulator.
// - Watchdog pre-clears clear both flags only when back to back.
`timescale 1ns/1ps
module mcu_exec_core #(
  parameter int PC_W = 14,
  parameter int STACK_DEPTH = 8
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_n_in,
  // Program memory
  output logic [PC_W-1:0] prog_addr_out,
  input wire logic [mcu_exec_pkg::INSTR_W-1:0] prog_data_in,
  // Wake pin and watchdog
  input wire logic wake_in,
  input wire logic wdt_timeout_in,
  output logic wdt_clear_out,
  output logic watchdog_timeout_flag_out,
  output logic powerdown_flag_out,
  output logic halted_out,
  // Observed state
  output logic instr_done_out,
  output logic [PC_W-1:0] pc_out,
  output logic [7:0] acc_out,
  output logic zero_flag_out,
  output logic carry_flag_out,
  output logic [7:0] tblh_out,
  output logic [7:0] port_out
);
  import mcu_exec_pkg::*;

  localparam int SP_W = $clog2(STACK_DEPTH);

  cyc_state_type state_r;
  logic [PH_W-1:0] phase_r;
  logic [PC_W-1:0] pc_r, pc_nxt, prog_addr_r, pc_inc1, pc_inc2;
  logic [PC_W-1:0] stack_r [STACK_DEPTH];
  logic [SP_W-1:0] sp_r;
  logic [DATA_W-1:0] mem_r [MEM_DEPTH];
  logic [DATA_W-1:0] acc_r, tblh_r, rd_val, src_val, res, tbl_dest_r;
  logic [DATA_W-1:0] bit_mask;
  logic [8:0] sum_w, diff_w;
  logic c_r, z_r, c_nxt, z_set, wr_en, acc_ld, two_cyc, skip, skip_op;
  logic push, pop, go_halt, go_table, exec_now, tbl_wr;
  logic wake_meta_r, wake_sync_r;
  logic to_r, pwrdn_r, wdt_clear_r;
  logic [1:0] pre_r;
  logic [OP_W-1:0] op_w;
  logic [2:0] bit_w;
  logic [7:0] opd_w;

  assign op_w = prog_data_in[OP_MSB:OP_LSB];
  assign bit_w = prog_data_in[BIT_MSB:BIT_LSB];
  assign opd_w = prog_data_in[OPD_MSB:0];
  assign pc_inc1 = pc_r + PC_W'(1);
  assign pc_inc2 = pc_r + PC_W'(2);
  assign exec_now = (state_r == run_st) && (phase_r == LAST_PHASE);
  assign tbl_wr = (state_r == table_st) && (phase_r == LAST_PHASE);
  assign bit_mask = ONE_BYTE << bit_w;
  // Pc low byte reads back the live counter, not a stored copy
  assign rd_val = (opd_w == PC_LOW_ADDR) ? pc_r[7:0] : mem_r[opd_w];
  assign src_val = (op_w == OP_ADD_AX || op_w == OP_SUB_AX ||
                    op_w == OP_AND_AX) ? opd_w : rd_val;
  assign sum_w = {1'b0, acc_r} + {1'b0, src_val};
  // Carry set means no borrow, so a result below zero clears it
  assign diff_w = {1'b0, acc_r} + {1'b0, ~src_val} + ONE_9;

  // Decode and execute; accumulator is one operand of add, subtract, and, or, xor
  always_comb begin
    res = acc_r;
    wr_en = 1'b0;
    acc_ld = 1'b0;
    c_nxt = c_r;
    z_set = 1'b0;
    pc_nxt = pc_inc1;
    two_cyc = 1'b0;
    skip_op = 1'b0;
    skip = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    go_halt = 1'b0;
    go_table = 1'b0;
    case (op_w)
      OP_XFER_AM: begin
        res = rd_val;
        acc_ld = 1'b1;
      end
      OP_XFER_MA: wr_en = 1'b1;
      OP_XFER_AX: begin
        res = opd_w;
        acc_ld = 1'b1;
      end
      OP_ADD_AM, OP_ADD_AX, OP_ADDM: begin
        res = sum_w[7:0];
        c_nxt = sum_w[8];
        z_set = 1'b1;
        acc_ld = (op_w != OP_ADDM);
        wr_en = (op_w == OP_ADDM);
      end
      OP_SUB_AM, OP_SUB_AX, OP_SUBM: begin
        res = diff_w[7:0];
        c_nxt = diff_w[8];
        z_set = 1'b1;
        acc_ld = (op_w != OP_SUBM);
        wr_en = (op_w == OP_SUBM);
      end
      OP_INC, OP_INC_ACC: begin
        res = rd_val + ONE_BYTE;
        z_set = 1'b1;
        acc_ld = (op_w == OP_INC_ACC);
        wr_en = (op_w == OP_INC);
      end
      OP_DECR_MEM, OP_DECR_ACC: begin
        res = rd_val - ONE_BYTE;
        z_set = 1'b1;
        acc_ld = (op_w == OP_DECR_ACC);
        wr_en = (op_w == OP_DECR_MEM);
      end
      OP_AND_AM, OP_AND_AX: begin
        res = acc_r & src_val;
        z_set = 1'b1;
        acc_ld = 1'b1;
      end
      OP_OR_AM: begin
        res = acc_r | rd_val;
        z_set = 1'b1;
        acc_ld = 1'b1;
      end
      OP_XOR_AM: begin
        res = acc_r ^ rd_val;
        z_set = 1'b1;
        acc_ld = 1'b1;
      end
      OP_INV_MEM, OP_INV_ACC: begin
        res = ~rd_val;
        z_set = 1'b1;
        acc_ld = (op_w == OP_INV_ACC);
        wr_en = (op_w == OP_INV_MEM);
      end
      OP_ROT_R: begin
        res = {rd_val[0], rd_val[7:1]};
        wr_en = 1'b1;
      end
      OP_ROT_L: begin
        res = {rd_val[6:0], rd_val[7]};
        wr_en = 1'b1;
      end
      OP_ROTC_R: begin
        res = {c_r, rd_val[7:1]};
        c_nxt = rd_val[0];
        wr_en = 1'b1;
      end
      OP_ROTC_L: begin
        res = {rd_val[6:0], c_r};
        c_nxt = rd_val[7];
        wr_en = 1'b1;
      end
      OP_GOTO: begin
        pc_nxt = prog_data_in[PC_W-1:0];
        two_cyc = 1'b1;
      end
      OP_CALL: begin
        pc_nxt = prog_data_in[PC_W-1:0];
        push = 1'b1;
        two_cyc = 1'b1;
      end
      OP_RETURN: begin
        pc_nxt = stack_r[sp_r - SP_W'(1)];
        pop = 1'b1;
        two_cyc = 1'b1;
      end
      OP_SZ: begin
        skip_op = 1'b1;
        skip = (rd_val == ZERO_BYTE);
      end
      OP_SZB: begin
        skip_op = 1'b1;
        skip = ~rd_val[bit_w];
      end
      OP_SNZB: begin
        skip_op = 1'b1;
        skip = rd_val[bit_w];
      end
      OP_SIZ, OP_SDZ: begin
        res = (op_w == OP_SIZ) ? rd_val + ONE_BYTE : rd_val - ONE_BYTE;
        wr_en = 1'b1;
        skip_op = 1'b1;
        skip = (res == ZERO_BYTE);
      end
      OP_SETB: begin
        res = rd_val | bit_mask;
        wr_en = 1'b1;
      end
      OP_CLRB: begin
        res = rd_val & ~bit_mask;
        wr_en = 1'b1;
      end
      OP_TABRD: go_table = 1'b1;
      OP_HALT: go_halt = 1'b1;
      default: ;
    endcase
    if (skip) begin
      pc_nxt = pc_inc2;
      two_cyc = 1'b1;
    end
    if (wr_en && opd_w == PC_LOW_ADDR) begin
      pc_nxt = {pc_r[PC_W-1:8], res};
      two_cyc = 1'b1;
    end
  end

  // Cycle sequencing: four phases per instruction cycle
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      phase_r <= '0;
    end else begin
      phase_r <= phase_r + PH_W'(1);
    end
  end

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r <= run_st;
    end else if (phase_r == LAST_PHASE) begin
      case (state_r)
        run_st: begin
          if (go_halt) begin
            state_r <= halt_st;
          end else if (go_table) begin
            state_r <= table_st;
          end else if (two_cyc) begin
            state_r <= extra_st;
          end
        end
        extra_st, table_st: state_r <= run_st;
        halt_st: begin
          if (wake_sync_r) begin
            state_r <= run_st;
          end
        end
        default: state_r <= run_st;
      endcase
    end
  end

  // Program counter and fetch address
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_r <= '0;
      prog_addr_r <= '0;
    end else if (exec_now) begin
      pc_r <= pc_nxt;
      prog_addr_r <= go_table ?
        {pc_r[PC_W-1:8], mem_r[TBLP_ADDR]} : pc_nxt;
    end else if (tbl_wr) begin
      prog_addr_r <= pc_r;
    end
  end

  // Return stack wraps when nesting goes past its depth
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sp_r <= '0;
      for (int i = 0; i < STACK_DEPTH; i++) begin
        stack_r[i] <= '0;
      end
    end else if (exec_now && push) begin
      stack_r[sp_r] <= pc_inc1;
      sp_r <= sp_r + SP_W'(1);
    end else if (exec_now && pop) begin
      sp_r <= sp_r - SP_W'(1);
    end
  end

  // Accumulator and flags
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_r <= '0;
      c_r <= 1'b0;
      z_r <= 1'b0;
    end else if (exec_now) begin
      c_r <= c_nxt;
      if (acc_ld) begin
        acc_r <= res;
      end
      if (z_set) begin
        z_r <= (res == ZERO_BYTE);
      end
    end
  end

  // Data memory, also written by the second cycle of a table read
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        mem_r[i] <= '0;
      end
      tbl_dest_r <= '0;
      tblh_r <= '0;
    end else if (exec_now) begin
      tbl_dest_r <= opd_w;
      if (wr_en && opd_w != PC_LOW_ADDR) begin
        mem_r[opd_w] <= res;
      end
    end else if (tbl_wr) begin
      tblh_r <= prog_data_in[TBL_HI_MSB:TBL_HI_LSB];
      if (tbl_dest_r != PC_LOW_ADDR) begin
        mem_r[tbl_dest_r] <= prog_data_in[OPD_MSB:0];
      end
    end
  end

  // Wake pin synchroniser
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wake_meta_r <= 1'b0;
      wake_sync_r <= 1'b0;
    end else begin
      wake_meta_r <= wake_in;
      wake_sync_r <= wake_meta_r;
    end
  end

  // Watchdog flags; a timeout in the clearing cycle still wins
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      to_r <= 1'b0;
      pwrdn_r <= 1'b0;
      pre_r <= PRE_NONE;
      wdt_clear_r <= 1'b0;
    end else begin
      wdt_clear_r <= 1'b0;
      if (exec_now) begin
        pre_r <= PRE_NONE;
        case (op_w)
          OP_CLRWDT: begin
            to_r <= 1'b0;
            pwrdn_r <= 1'b0;
            wdt_clear_r <= 1'b1;
          end
          OP_CLRWDT1, OP_CLRWDT2: begin
            pre_r <= (op_w == OP_CLRWDT1) ? PRE_ONE : PRE_TWO;
            if ((op_w == OP_CLRWDT1 && pre_r == PRE_TWO) ||
                (op_w == OP_CLRWDT2 && pre_r == PRE_ONE)) begin
              to_r <= 1'b0;
              pwrdn_r <= 1'b0;
              wdt_clear_r <= 1'b1;
              pre_r <= PRE_NONE;
            end
          end
          OP_HALT: begin
            to_r <= 1'b0;
            pwrdn_r <= 1'b1;
            wdt_clear_r <= 1'b1;
          end
          default: ;
        endcase
      end
      if (wdt_timeout_in) begin
        to_r <= 1'b1;
      end
    end
  end

  assign prog_addr_out = prog_addr_r;
  assign wdt_clear_out = wdt_clear_r;
  assign watchdog_timeout_flag_out = to_r;
  assign powerdown_flag_out = pwrdn_r;
  assign halted_out = (state_r == halt_st);
  assign instr_done_out = exec_now;
  assign pc_out = pc_r;
  assign acc_out = acc_r;
  assign zero_flag_out = z_r;
  assign carry_flag_out = c_r;
  assign tblh_out = tblh_r;
  assign port_out = mem_r[PORT_ADDR];

  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  instr_spacing_a: assert property (
    instr_done_out |=> !instr_done_out [*3])
    else $error("instruction done closer than four clocks");
  jump_two_cyc_a: assert property (
    (exec_now && op_w == OP_GOTO) |=> (state_r == extra_st) [*4]
      ##1 state_r == run_st)
    else $error("jump did not take exactly two cycles");
  pc_low_write_a: assert property (
    (exec_now && wr_en && opd_w == PC_LOW_ADDR) |=>
      pc_r[7:0] == $past(res) && state_r == extra_st)
    else $error("pc low write did not jump");
  skip_taken_a: assert property (
    (exec_now && skip) |=> pc_r == $past(pc_inc2) && state_r == extra_st)
    else $error("taken skip wrong");
  no_skip_a: assert property (
    (exec_now && skip_op && !skip && !(wr_en && opd_w == PC_LOW_ADDR)) |=>
      pc_r == $past(pc_inc1) && state_r == run_st)
    else $error("untaken skip wrong");
  add_carry_a: assert property (
    (exec_now && op_w == OP_ADD_AX) |=>
      {c_r, acc_r} == {1'b0, $past(acc_r)} + {1'b0, $past(opd_w)})
    else $error("add result or carry wrong");
  bit_rmw_a: assert property (
    (exec_now && (op_w == OP_SETB || op_w == OP_CLRB)) |->
      (res & ~bit_mask) == (rd_val & ~bit_mask))
    else $error("bit operation touched other bits");
  call_save_a: assert property (
    (exec_now && op_w == OP_CALL) |=>
      stack_r[$past(sp_r)] == $past(pc_inc1) &&
      sp_r == $past(sp_r) + SP_W'(1))
    else $error("call did not save return address");
  wdt_pair_a: assert property (
    (exec_now && !wdt_timeout_in &&
     ((op_w == OP_CLRWDT2 && pre_r == PRE_ONE) ||
      (op_w == OP_CLRWDT1 && pre_r == PRE_TWO))) |=>
      !to_r && !pwrdn_r && wdt_clear_out)
    else $error("pre-clear pair did not clear flags");
  halt_enter_a: assert property (
    (exec_now && op_w == OP_HALT) |=> (halted_out && pwrdn_r) [*2])
    else $error("halt did not power down");

  jump_seen_c: cover property (exec_now && op_w == OP_GOTO);
  skip_seen_c: cover property (exec_now && skip);
  table_seen_c: cover property (tbl_wr);
  wdt_pair_c: cover property (exec_now &&
    ((op_w == OP_CLRWDT2 && pre_r == PRE_ONE) ||
     (op_w == OP_CLRWDT1 && pre_r == PRE_TWO)));
endmodule

// >>> logic/mcu_exec_pkg.sv
// Shared constants and types for the instruction execution core
package mcu_exec_pkg;
  localparam int PHASES = 4;
  localparam int PH_W = $clog2(PHASES);
  localparam logic [PH_W-1:0] LAST_PHASE = PH_W'(PHASES - 1);
  localparam int DATA_W = 8;
  localparam int MEM_DEPTH = 256;
  localparam int INSTR_W = 22;
  localparam int OP_MSB = 21;
  localparam int OP_LSB = 16;
  localparam int OP_W = OP_MSB - OP_LSB + 1;
  localparam int BIT_MSB = 10;
  localparam int BIT_LSB = 8;
  localparam int OPD_MSB = 7;
  localparam int TBL_HI_MSB = 15;
  localparam int TBL_HI_LSB = 8;
  localparam logic [7:0] PC_LOW_ADDR = 8'h06;
  localparam logic [7:0] TBLP_ADDR = 8'h07;
  localparam logic [7:0] PORT_ADDR = 8'h14;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] ONE_BYTE = 8'h01;
  localparam logic [8:0] ONE_9 = 9'h001;
  localparam logic [1:0] PRE_NONE = 2'h0;
  localparam logic [1:0] PRE_ONE = 2'h1;
  localparam logic [1:0] PRE_TWO = 2'h2;
  localparam logic [OP_W-1:0]
    OP_NOP = 6'h00, OP_XFER_AM = 6'h01, OP_XFER_MA = 6'h02,
    OP_XFER_AX = 6'h03, OP_ADD_AM = 6'h04, OP_ADD_AX = 6'h05,
    OP_ADDM = 6'h06, OP_SUB_AM = 6'h07, OP_SUB_AX = 6'h08,
    OP_SUBM = 6'h09, OP_INC = 6'h0A, OP_INC_ACC = 6'h0B,
    OP_DECR_MEM = 6'h0C, OP_DECR_ACC = 6'h0D, OP_AND_AM = 6'h0E,
    OP_OR_AM = 6'h0F, OP_XOR_AM = 6'h10, OP_AND_AX = 6'h11,
    OP_INV_MEM = 6'h12, OP_INV_ACC = 6'h13, OP_ROT_R = 6'h14,
    OP_ROT_L = 6'h15, OP_ROTC_R = 6'h16, OP_ROTC_L = 6'h17,
    OP_GOTO = 6'h18, OP_CALL = 6'h19, OP_RETURN = 6'h1A,
    OP_SZ = 6'h1B, OP_SZB = 6'h1C, OP_SNZB = 6'h1D,
    OP_SIZ = 6'h1E, OP_SDZ = 6'h1F, OP_SETB = 6'h20,
    OP_CLRB = 6'h21, OP_TABRD = 6'h22, OP_HALT = 6'h23,
    OP_CLRWDT = 6'h24, OP_CLRWDT1 = 6'h25, OP_CLRWDT2 = 6'h26;
  typedef enum {run_st, extra_st, table_st, halt_st} cyc_state_type;
endpackage

// >>> verif/mcu_instruction_execution_tb.sv
// Self-checking testbench for the instruction execution core
`timescale 1ns/1ps
module mcu_instruction_execution_tb;
  import mcu_exec_pkg::*;
  logic clk_sys_in;
  logic rst_n_in;
  logic wake_in;
  logic wdt_timeout_in;
  logic [INSTR_W-1:0] prog_data_in;
  logic [13:0] prog_addr_out;
  logic [13:0] pc_out;
  logic wdt_clear_out;
  logic watchdog_timeout_flag_out;
  logic powerdown_flag_out;
  logic halted_out;
  logic instr_done_out;
  logic zero_flag_out;
  logic carry_flag_out;
  logic [7:0] acc_out;
  logic [7:0] tblh_out;
  logic [7:0] port_out;
  logic [INSTR_W-1:0] rom [64];
  int stamp [64];
  int cyc = 0;
  int clr_cnt;
  int errors;
  int tests_run;

  mcu_exec_core #(.PC_W(14), .STACK_DEPTH(8)) DUT (
    .clk_sys_in(clk_sys_in),
    .rst_n_in(rst_n_in),
    .prog_addr_out(prog_addr_out),
    .prog_data_in(prog_data_in),
    .wake_in(wake_in),
    .wdt_timeout_in(wdt_timeout_in),
    .wdt_clear_out(wdt_clear_out),
    .watchdog_timeout_flag_out(watchdog_timeout_flag_out),
    .powerdown_flag_out(powerdown_flag_out),
    .halted_out(halted_out),
    .instr_done_out(instr_done_out),
    .pc_out(pc_out),
    .acc_out(acc_out),
    .zero_flag_out(zero_flag_out),
    .carry_flag_out(carry_flag_out),
    .tblh_out(tblh_out),
    .port_out(port_out)
  );

  initial begin
    clk_sys_in = 1'b0;
    forever #25 clk_sys_in = ~clk_sys_in;
  end

  // Program memory answers one clock late, well inside the 4-clock window
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    prog_data_in <= rom[prog_addr_out[5:0]];
  end

  // Clock stamp of each executed address, and watchdog clear pulses
  always @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      foreach (stamp[k]) stamp[k] <= -1;
      clr_cnt <= 0;
    end else begin
      if (instr_done_out === 1'b1) stamp[pc_out[5:0]] <= cyc;
      if (wdt_clear_out === 1'b1) clr_cnt <= clr_cnt + 1;
    end
  end

  function automatic logic [21:0] w(logic [5:0] o, int b, int d);
    return {o, 5'h00, 3'(b), 8'(d)};
  endfunction

  function automatic logic [21:0] wj(logic [5:0] o, int t);
    return {o, 2'h0, 14'(t)};
  endfunction

  task automatic fail(string m);
    errors++;
    $display("FAIL %0t %s", $time, m);
  endtask

  task automatic chk8(logic [7:0] g, logic [7:0] e, string m);
    tests_run++;
    if (g !== e) fail(m);
  endtask

  task automatic chk1(logic g, logic e, string m);
    tests_run++;
    if (g !== e) fail(m);
  endtask

  task automatic chk_gap(int a, int b, int e);
    tests_run++;
    if (stamp[a] < 0 || stamp[b] - stamp[a] != e) fail("cycle spacing");
  endtask

  task automatic chk_skip(int a);
    tests_run++;
    if (stamp[a] != -1) fail("skipped address executed");
  endtask

  task automatic clear_rom;
    foreach (rom[k]) rom[k] = w(OP_NOP, 0, 0);
  endtask

  // Reset is held ten clocks, so the preloaded word 0 is settled at release
  task automatic start;
    @(posedge clk_sys_in);
    rst_n_in <= 1'b0;
    repeat (10) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
  endtask

  task automatic run_to(int a);
    int n;
    n = 0;
    while (pc_out !== 14'(a) && n < 400) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    if (n >= 400) fail("pc never arrived");
  endtask

  task automatic t_arith;
    clear_rom;
    rom[0] = w(OP_XFER_AX, 0, 8'hF0);
    rom[1] = w(OP_ADD_AX, 0, 8'h20);
    rom[2] = w(OP_XFER_MA, 0, 8'h14);
    rom[3] = w(OP_SUB_AX, 0, 8'h11);
    rom[4] = w(OP_INC, 0, 8'h14);
    rom[5] = w(OP_DECR_ACC, 0, 8'h14);
    rom[6] = w(OP_AND_AX, 0, 8'h00);
    rom[7] = wj(OP_GOTO, 7);
    start;
    run_to(2);
    chk8(acc_out, 8'h10, "sum wraps");
    chk1(carry_flag_out, 1'b1, "carry above 255");
    run_to(3);
    chk8(port_out, 8'h10, "acc to memory");
    run_to(4);
    chk8(acc_out, 8'hFF, "difference");
    chk1(carry_flag_out, 1'b0, "borrow below zero");
    run_to(5);
    chk8(port_out, 8'h11, "increment");
    run_to(6);
    chk8(acc_out, 8'h10, "decrement into acc");
    chk1(zero_flag_out, 1'b0, "nonzero result");
    run_to(7);
    chk8(acc_out, 8'h00, "and result");
    chk1(zero_flag_out, 1'b1, "zero after and");
    chk_gap(0, 1, 4);
    chk_gap(5, 6, 4);
  endtask

  task automatic t_branch;
    clear_rom;
    rom[0] = w(OP_XFER_AX, 0, 8'h01);
    rom[1] = wj(OP_GOTO, 3);
    rom[2] = w(OP_XFER_AX, 0, 8'h55);
    rom[3] = wj(OP_CALL, 8);
    rom[4] = w(OP_XFER_AX, 0, 8'h22);
    rom[5] = wj(OP_GOTO, 5);
    rom[8] = w(OP_XFER_AX, 0, 8'h33);
    rom[9] = w(OP_RETURN, 0, 0);
    start;
    run_to(8);
    chk8(acc_out, 8'h01, "jump skipped nothing wrong");
    run_to(9);
    chk8(acc_out, 8'h33, "subroutine body");
    run_to(5);
    chk8(acc_out, 8'h22, "resumed after call");
    chk_skip(2);
    chk_gap(1, 3, 8);
    chk_gap(3, 8, 8);
    chk_gap(9, 4, 8);
  endtask

  task automatic t_skip;
    clear_rom;
    rom[0] = w(OP_XFER_AX, 0, 8'h81);
    rom[1] = w(OP_XFER_MA, 0, 8'h14);
    rom[2] = w(OP_SZB, 0, 8'h14);
    rom[3] = w(OP_SNZB, 7, 8'h14);
    rom[4] = w(OP_XFER_AX, 0, 8'h55);
    rom[5] = w(OP_CLRB, 7, 8'h14);
    rom[6] = w(OP_SETB, 3, 8'h14);
    rom[7] = w(OP_SDZ, 0, 8'h14);
    rom[8] = w(OP_SZ, 0, 8'h15);
    rom[9] = w(OP_XFER_AX, 0, 8'h66);
    rom[10] = w(OP_XFER_AX, 0, 8'h0E);
    rom[11] = w(OP_XFER_MA, 0, 8'h06);
    rom[12] = w(OP_XFER_AX, 0, 8'h77);
    rom[15] = wj(OP_GOTO, 15);
    start;
    run_to(6);
    chk8(port_out, 8'h01, "bit cleared alone");
    chk8(acc_out, 8'h81, "skipped move");
    run_to(7);
    chk8(port_out, 8'h09, "bit set alone");
    run_to(15);
    chk8(port_out, 8'h08, "decrement then test");
    chk8(acc_out, 8'h0E, "pc low write jumped");
    chk_gap(2, 3, 4);
    chk_gap(3, 5, 8);
    chk_gap(7, 8, 4);
    chk_gap(8, 10, 8);
    chk_gap(11, 14, 8);
    chk_skip(4);
    chk_skip(9);
    chk_skip(12);
  endtask

  task automatic t_rot;
    clear_rom;
    rom[0] = w(OP_XFER_AX, 0, 8'h81);
    rom[1] = w(OP_XFER_MA, 0, 8'h14);
    rom[2] = w(OP_ROT_R, 0, 8'h14);
    rom[3] = w(OP_ROT_L, 0, 8'h14);
    rom[4] = w(OP_ROTC_R, 0, 8'h14);
    rom[5] = w(OP_ROTC_L, 0, 8'h14);
    rom[6] = w(OP_INV_MEM, 0, 8'h14);
    rom[7] = w(OP_XFER_AX, 0, 8'hFF);
    rom[8] = w(OP_XFER_MA, 0, 8'h15);
    rom[9] = w(OP_INV_MEM, 0, 8'h15);
    rom[10] = w(OP_XFER_AX, 0, 8'h30);
    rom[11] = w(OP_XFER_MA, 0, 8'h07);
    rom[12] = w(OP_TABRD, 0, 8'h14);
    rom[14] = wj(OP_GOTO, 14);
    rom[48] = 22'h00A55A;
    start;
    run_to(3);
    chk8(port_out, 8'hC0, "rotate right");
    run_to(4);
    chk8(port_out, 8'h81, "rotate left");
    run_to(5);
    chk8(port_out, 8'h40, "right through carry");
    chk1(carry_flag_out, 1'b1, "bit out to carry");
    run_to(6);
    chk8(port_out, 8'h81, "left through carry");
    chk1(carry_flag_out, 1'b0, "carry refilled");
    run_to(7);
    chk8(port_out, 8'h7E, "complement");
    chk1(zero_flag_out, 1'b0, "complement nonzero");
    run_to(10);
    chk1(zero_flag_out, 1'b1, "complement zero");
    run_to(14);
    chk8(tblh_out, 8'hA5, "table high byte");
    chk8(port_out, 8'h5A, "table low byte");
    chk_gap(12, 13, 8);
  endtask

  task automatic t_wdt;
    int n;
    clear_rom;
    rom[1] = w(OP_HALT, 0, 0);
    rom[2] = w(OP_XFER_AX, 0, 8'h11);
    rom[3] = w(OP_CLRWDT1, 0, 0);
    rom[5] = w(OP_CLRWDT2, 0, 0);
    rom[6] = w(OP_CLRWDT2, 0, 0);
    rom[7] = w(OP_CLRWDT1, 0, 0);
    rom[9] = wj(OP_GOTO, 9);
    start;
    n = 0;
    while (halted_out !== 1'b1 && n < 100) begin
      @(posedge clk_sys_in);
      #1;
      n++;
    end
    // Halt must hold with no wake, so the next move must not run
    repeat (20) @(posedge clk_sys_in);
    #1;
    chk1(halted_out, 1'b1, "halt holds");
    chk1(powerdown_flag_out, 1'b1, "power-down flag");
    chk8(acc_out, 8'h00, "nothing ran in halt");
    @(posedge clk_sys_in);
    wake_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
    wake_in <= 1'b0;
    run_to(3);
    chk1(halted_out, 1'b0, "woken");
    chk8(acc_out, 8'h11, "resumed after halt");
    @(posedge clk_sys_in);
    wdt_timeout_in <= 1'b1;
    @(posedge clk_sys_in);
    wdt_timeout_in <= 1'b0;
    run_to(6);
    chk1(watchdog_timeout_flag_out, 1'b1, "split pair keeps");
    chk1(powerdown_flag_out, 1'b1, "split pair keeps");
    run_to(7);
    chk1(watchdog_timeout_flag_out, 1'b1, "same twice keeps");
    run_to(8);
    chk1(watchdog_timeout_flag_out, 1'b0, "pair clears");
    chk1(powerdown_flag_out, 1'b0, "pair clears");
    run_to(9);
    chk8(8'(clr_cnt), 8'h02, "watchdog clear pulses");
  endtask

  task automatic print_verdict;
    if (errors == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fail("run timed out");
    print_verdict;
  end

  initial begin
    rst_n_in = 1'b0;
    wake_in = 1'b0;
    wdt_timeout_in = 1'b0;
    errors = 0;
    tests_run = 0;
    t_arith;
    t_branch;
    t_skip;
    t_rot;
    t_wdt;
    print_verdict;
  end
endmodule
